// file: angle_seq.v
// angle measurement sequencer with sleep, interrupt pin and serial slave
// Operation
// - after reset, run start-up sequence containing exactly one measurement
// - start-up result is latched into angle register and interrupt signalled
// - after signalling completion the sequencer goes to sleep
// - reading the angle over serial deasserts the interrupt
// - an angle read request wakes the sequencer and starts a measurement
// - completion of requested measurement stores angle, sets interrupt and ready flag
// - each wake runs one measurement of about 600 us, then sleep
// - no averaging; each stored angle comes from a single measurement
// - while asleep no measurement happens until an angle read arrives
// - interrupt pin is active low, driven low when conversion finishes
// - wire-select low gives three-wire, high gives four-wire serial
// - interrupt-enable input gates whether the interrupt pin is driven
// - angle register is unsigned 12 bits, reads 0x000 after reset
// - configuration bits 13:12 read 00 for 12-bit resolution
// - input sampled on falling clock, output driven on rising, 16 clocks
// - a read takes two frames; data returns in the second frame
`timescale 1ns/1ps
`default_nettype none
`include "angle_seq_map.vh"
module angle_seq #(
   parameter MEAS_CYCLES = `MEAS_CYCLES
) (
   input  wire             sys_clk,
   input  wire             rst_n,
   input  wire             sck,
   input  wire             ss_n,
   input  wire             mosi,
   input  wire             sdio_in,
   input  wire             wire_mode,
   input  wire             en_int_n,
   input  wire [11:0]      sample,
   output reg              miso_q,
   output reg              miso_oe_n_q,
   output reg              sdio_out_q,
   output reg              sdio_oe_n_q,
   output reg              int_n_q,
   output reg              int_oe_n_q,
   output reg              awake_q,
   output reg              ready_q
);
   localparam S_BOOT  = 2'h0;
   localparam S_MEAS  = 2'h1;
   localparam S_SLEEP = 2'h2;

   reg  [5:0]  meta_q;
   reg  [5:0]  sync_q;
   reg         sck_prev_q;
   reg         ss_prev_q;
   reg  [1:0]  state_q;
   reg  [1:0]  boot_q;
   reg         four_wire_q;
   reg         start_q;
   reg  [11:0] angle_q;
   reg         int_q;
   reg         err_q;
   reg  [4:0]  bit_cnt_q;
   reg  [15:0] rx_q;
   reg  [15:0] tx_q;
   reg  [13:0] resp_q;
   reg         data_phase_q;
   reg         reply_q;
   reg         angle_rd_q;
   wire        busy;
   wire        done;
   wire [11:0] eng_angle;
   wire        sck_s;
   wire        ss_s;
   wire        din_s;
   wire        en_int_s;
   wire        sck_rise;
   wire        sck_fall;
   wire        ss_fall;
   wire        ss_rise;
   wire        frame_ok;
   wire [13:0] rx_addr;
   wire [13:0] cfg_word;

   // =====================================================================
   // input synchronisers
   // two stages on every pin from outside the clock domain
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         // idle levels: sck low, select high, interrupt gate off
         meta_q <= 6'h32;
         sync_q <= 6'h32;
      end else begin
         meta_q <= {wire_mode, en_int_n, sdio_in, mosi, ss_n, sck};
         sync_q <= meta_q;
      end
   end

   assign sck_s    = sync_q[0];
   assign ss_s     = sync_q[1];
   assign din_s    = four_wire_q ? sync_q[2] : sync_q[3];
   assign en_int_s = sync_q[4];

   // edge detection on the synchronised link clock and select
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_prev_q <= 1'b0;
         ss_prev_q  <= 1'b1;
      end else begin
         sck_prev_q <= sck_s;
         ss_prev_q  <= ss_s;
      end
   end

   assign sck_rise = ~ss_s & sck_s & ~sck_prev_q;
   assign sck_fall = ~ss_s & ~sck_s & sck_prev_q;
   assign ss_fall  = ss_prev_q & ~ss_s;
   assign ss_rise  = ~ss_prev_q & ss_s;
   assign frame_ok = (bit_cnt_q == `FRAME_BITS_W) && ~(^rx_q);
   assign rx_addr  = rx_q[14:1];
   assign cfg_word = {`RES_CODE_12BIT, 11'h000, ready_q};

   // =====================================================================
   // measurement engine
   meas_timer #(
      .MEAS_CYCLES (MEAS_CYCLES),
      .CNT_W       (18)
   ) u_meas (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .start   (start_q),
      .sample  (sample),
      .busy_q  (busy),
      .done_q  (done),
      .angle_q (eng_angle)
   );

   // =====================================================================
   // power sequencer
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q     <= S_BOOT;
         boot_q      <= 2'h0;
         four_wire_q <= 1'b0;
         start_q     <= 1'b0;
         awake_q     <= 1'b1;
      end else begin
         start_q <= 1'b0;
         case (state_q)
            S_BOOT: begin
               boot_q <= boot_q + 1'b1;
               if (boot_q == `BOOT_CYCLES) begin
                  four_wire_q <= sync_q[5];
                  start_q     <= 1'b1;
                  state_q     <= S_MEAS;
               end
            end
            S_MEAS: begin
               // a read here does not restart the window
               if (done) begin
                  state_q <= S_SLEEP;
                  awake_q <= 1'b0;
               end
            end
            S_SLEEP: begin
               if (angle_rd_q) begin
                  start_q <= 1'b1;
                  awake_q <= 1'b1;
                  state_q <= S_MEAS;
               end
            end
            default: begin
               state_q <= S_SLEEP;
               awake_q <= 1'b0;
            end
         endcase
      end
   end

   // =====================================================================
   // result, interrupt and ready flag; a set wins over a clear
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         angle_q    <= `ANGLE_RESET;
         int_q      <= 1'b0;
         ready_q    <= 1'b0;
         int_n_q    <= 1'b1;
         int_oe_n_q <= 1'b1;
      end else begin
         if (done) begin
            angle_q <= eng_angle;
            int_q   <= 1'b1;
            ready_q <= 1'b1;
         end else if (angle_rd_q) begin
            int_q   <= 1'b0;
            ready_q <= 1'b0;
         end
         int_n_q    <= ~int_q;
         int_oe_n_q <= en_int_s;
      end
   end

   // =====================================================================
   // serial slave: frame shift, decode and reply
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt_q    <= 5'h00;
         rx_q         <= 16'h0000;
         tx_q         <= 16'h0000;
         resp_q       <= 14'h0000;
         err_q        <= 1'b0;
         data_phase_q <= 1'b0;
         reply_q      <= 1'b0;
         angle_rd_q   <= 1'b0;
      end else begin
         angle_rd_q <= 1'b0;
         if (ss_fall) begin
            bit_cnt_q <= 5'h00;
            // even parity over the whole frame
            tx_q      <= {resp_q, err_q, ^{resp_q, err_q}};
         end else if (sck_rise && (bit_cnt_q != 5'h00)) begin
            // msb stands through the first rise, later rises shift
            tx_q <= {tx_q[14:0], 1'b0};
         end
         if (sck_fall) begin
            rx_q <= {rx_q[14:0], din_s};
            if (bit_cnt_q != 5'h1F) begin
               bit_cnt_q <= bit_cnt_q + 1'b1;
            end
         end
         if (ss_rise) begin
            resp_q  <= 14'h0000;
            reply_q <= 1'b0;
            if (reply_q && !four_wire_q) begin
               // line was ours during this frame, nothing to decode
            end else if (!frame_ok) begin
               err_q        <= 1'b1;
               data_phase_q <= 1'b0;
            end else if (data_phase_q) begin
               data_phase_q <= 1'b0;
            end else if (rx_q[15]) begin
               reply_q <= 1'b1;
               if (rx_addr == `ADDR_ANGLE_RESULT) begin
                  resp_q     <= {2'h0, angle_q};
                  angle_rd_q <= 1'b1;
               end else if (rx_addr == `ADDR_CONFIG_ONE) begin
                  resp_q <= cfg_word;
               end else if (rx_addr == `ADDR_CLR_ERROR) begin
                  err_q <= 1'b0;
               end
            end else if (rx_addr != `ADDR_NOP) begin
               data_phase_q <= 1'b1;
            end
         end
      end
   end

   // =====================================================================
   // pin drivers
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         miso_q      <= 1'b0;
         miso_oe_n_q <= 1'b1;
         sdio_out_q  <= 1'b0;
         sdio_oe_n_q <= 1'b1;
      end else begin
         miso_q      <= tx_q[15];
         sdio_out_q  <= tx_q[15];
         miso_oe_n_q <= ~(four_wire_q & ~ss_s);
         sdio_oe_n_q <= ~(~four_wire_q & ~ss_s & reply_q);
      end
   end
endmodule
`default_nettype wire

// file: angle_seq_map.vh
// constants for the angle measurement sleep sequencer
`ifndef ANGLE_SEQ_MAP_VH
`define ANGLE_SEQ_MAP_VH

// register offsets (14-bit addresses)
`define ADDR_CONFIG_ONE    14'h3F20
`define ADDR_ANGLE_RESULT  14'h3FFF
`define ADDR_CLR_ERROR     14'h3380
`define ADDR_NOP           14'h0000

// config_one field layout
`define RES_CODE_MSB       13
`define RES_CODE_LSB       12
`define RES_CODE_12BIT     2'h0
`define READY_BIT          0

// reset values
`define ANGLE_RESET        12'h000

// serial frame
`define FRAME_BITS         16
`define FRAME_BITS_W       5'h10

// timing
`define CLK_PERIOD_NS      4
`define MEAS_TIME_NS       600000
`define MEAS_CYCLES        (`MEAS_TIME_NS / `CLK_PERIOD_NS)
`define BOOT_CYCLES        2'h3

`endif

// file: meas_timer.v
// one-shot angle measurement timer with single-sample capture
`timescale 1ns/1ps
`default_nettype none
module meas_timer #(
   parameter MEAS_CYCLES = 150000,
   parameter CNT_W       = 18
) (
   input  wire             sys_clk,
   input  wire             rst_n,
   input  wire             start,
   input  wire [11:0]      sample,
   output reg              busy_q,
   output reg              done_q,
   output reg  [11:0]      angle_q
);
   reg [CNT_W-1:0] cnt_q;

   // =====================================================================
   // measurement window
   // one window per start, one sample taken at its end, no averaging
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q  <= 1'b0;
         done_q  <= 1'b0;
         cnt_q   <= {CNT_W{1'b0}};
         angle_q <= 12'h000;
      end else begin
         done_q <= 1'b0;
         if (busy_q) begin
            if (cnt_q == MEAS_CYCLES[CNT_W-1:0] - 1'b1) begin
               busy_q  <= 1'b0;
               done_q  <= 1'b1;
               angle_q <= sample;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end else if (start) begin
            busy_q <= 1'b1;
            cnt_q  <= {CNT_W{1'b0}};
         end
      end
   end
endmodule
`default_nettype wire

// file: angle_seq_properties.sv
// port assertions for the angle measurement sequencer
`timescale 1ns/1ps
`default_nettype none
module angle_seq_properties #(
   parameter MEAS_CYCLES = 2000
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ss_n,
   input wire logic en_int_n,
   input wire logic miso_oe_n_q,
   input wire logic sdio_oe_n_q,
   input wire logic int_n_q,
   input wire logic int_oe_n_q,
   input wire logic awake_q,
   input wire logic ready_q
);
   reg        ss_prev_q;
   reg [3:0]  since_q;
   reg [31:0] awake_cnt_q;
   // ======
   // age of last frame end and length of awake spell
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ss_prev_q   <= 1'b1;
         since_q     <= 4'hF;
         awake_cnt_q <= 32'h0;
      end else begin
         ss_prev_q   <= ss_n;
         since_q     <= (ss_n && !ss_prev_q) ? 4'h0 : (&since_q ? since_q : since_q + 4'h1);
         awake_cnt_q <= awake_q ? awake_cnt_q + 32'h1 : 32'h0;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_done;
      ##[0:1] (ready_q && !awake_q && !int_n_q);
   endsequence
   sequence s_cleared;
      ##[0:1] (int_n_q && !ready_q);
   endsequence
   a_done_flags: assert property ($fell(int_n_q) |-> s_done)
      else $error("done flags wrong");
   a_sleep_after: assert property ($fell(awake_q) |-> s_done)
      else $error("sleep without done");
   a_read_clears: assert property ($fell(ready_q) |-> s_cleared)
      else $error("ready fell alone");
   a_int_from_frame: assert property ($rose(int_n_q) |-> since_q < 4'hA)
      else $error("int cleared without frame");
   a_no_self_wake: assert property ($rose(awake_q) |-> since_q < 4'hA)
      else $error("woke without frame");
   a_one_shot: assert property ($fell(awake_q) |->
      awake_cnt_q >= MEAS_CYCLES - 2 && awake_cnt_q <= MEAS_CYCLES + 10)
      else $error("measurement length wrong");
   a_int_gate: assert property (!en_int_n [*5] |-> !int_oe_n_q)
      else $error("int pin not driven");
   a_one_driver: assert property (!miso_oe_n_q |-> sdio_oe_n_q)
      else $error("two reply drivers");
endmodule
bind angle_seq angle_seq_properties #(.MEAS_CYCLES(MEAS_CYCLES)) i_props (
   .sys_clk(sys_clk), .rst_n(rst_n), .ss_n(ss_n), .en_int_n(en_int_n),
   .miso_oe_n_q(miso_oe_n_q), .sdio_oe_n_q(sdio_oe_n_q), .int_n_q(int_n_q),
   .int_oe_n_q(int_oe_n_q), .awake_q(awake_q), .ready_q(ready_q));
`default_nettype wire

// file: spi_host.sv
// host microcontroller model acting as serial master
`timescale 1ns/1ps
`default_nettype none
module spi_host (
   input  wire logic sys_clk,
   output var logic  sck,
   output var logic  ss_n,
   output var logic  mosi,
   input  wire logic din
);
   initial begin
      sck  = 1'b0;
      ss_n = 1'b1;
      mosi = 1'b0;
   end
   // ======
   // one 16-bit frame, msb first, 160 ns serial clock
   task xfer(input logic [15:0] tx, output logic [15:0] rx);
      integer i;
      begin
         @(posedge sys_clk);
         ss_n <= 1'b0;
         repeat (20) @(posedge sys_clk);
         for (i = 15; i >= 0; i = i - 1) begin
            sck  <= 1'b1; // shift on rising
            mosi <= tx[i];
            repeat (20) @(posedge sys_clk);
            sck   <= 1'b0;
            rx[i] = din; // reply taken at falling edge
            repeat (20) @(posedge sys_clk);
         end
         ss_n <= 1'b1; // deselect after 16 clocks
         mosi <= ~mosi; // released line shows no stale bit
         repeat (8) @(posedge sys_clk);
         #1;
      end
   endtask
endmodule
`default_nettype wire

// file: angle_seq_bench.sv
// self-checking bench for the angle measurement sequencer
`timescale 1ns/1ps
`default_nettype none
`include "angle_seq_map.vh"
module angle_seq_bench;
   localparam MC = 2000;
   reg        sys_clk, rst_n, wire_mode, en_int_n;
   reg [11:0] sample;
   reg [15:0] rx;
   reg [23:0] rows [0:4];
   wire       sck, ss_n, mosi, miso_q, miso_oe_n_q, sdio_out_q, sdio_oe_n_q;
   wire       int_n_q, int_oe_n_q, awake_q, ready_q;
   integer    errors, total_checks, t0, i;
   integer    cyc = 0;
   // ======
   // shared reply line and pulled-up interrupt pin
   wire sdio_line = sdio_oe_n_q ? mosi : sdio_out_q;
   wire rx_line   = miso_oe_n_q ? sdio_line : miso_q;
   wire int_line  = int_oe_n_q ? 1'b1 : int_n_q;
   angle_seq #(.MEAS_CYCLES(MC)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .sck(sck),
      .ss_n(ss_n), .mosi(mosi), .sdio_in(sdio_line), .wire_mode(wire_mode),
      .en_int_n(en_int_n), .sample(sample), .miso_q(miso_q), .miso_oe_n_q(miso_oe_n_q),
      .sdio_out_q(sdio_out_q), .sdio_oe_n_q(sdio_oe_n_q), .int_n_q(int_n_q),
      .int_oe_n_q(int_oe_n_q), .awake_q(awake_q), .ready_q(ready_q));
   spi_host i_host (.sys_clk(sys_clk), .sck(sck), .ss_n(ss_n), .mosi(mosi), .din(rx_line));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) cyc <= cyc + 1;
   function [15:0] cmd(input rw, input [13:0] a);
      cmd = {rw, a, ^{rw, a}};
   endfunction
   function [15:0] reply(input [13:0] d);
      reply = {d, 1'b0, ^d};
   endfunction
   task check(input [15:0] got, input [15:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task wait_int;
      integer k;
      begin
         k = 0;
         while (int_n_q !== 1'b0 && k < 3000) begin
            @(posedge sys_clk);
            #1;
            k = k + 1;
         end
         check({14'h0, int_line, ready_q}, 16'h0001);
      end
   endtask
   task print_verdict;
      begin
         if (errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial begin
      #200000;
      errors = errors + 1;
      print_verdict;
   end
   // ======
   // start-up, table of reads, then three-wire mode
   initial begin
      rst_n = 1'b0;
      wire_mode = 1'b1;
      en_int_n = 1'b0;
      sample = 12'h5A5;
      errors = 0;
      total_checks = 0;
      rows[0] = 24'hABC5A5;
      rows[1] = 24'hFFFABC;
      rows[2] = 24'h000FFF;
      rows[3] = 24'h800000;
      rows[4] = 24'h001800;
      repeat (2) @(posedge sys_clk);
      #1;
      check({12'h0, int_n_q, awake_q, ready_q, miso_oe_n_q}, 16'h000D);
      @(posedge sys_clk);
      rst_n <= 1'b1;
      t0 = cyc;
      i_host.xfer(cmd(1'b1, `ADDR_ANGLE_RESULT), rx);
      i_host.xfer(cmd(1'b0, `ADDR_NOP), rx);
      check(rx, reply(14'h0000));
      check({14'h0, int_n_q, awake_q}, 16'h0003);
      wait_int;
      check({15'h0, (cyc - t0 >= MC - 2) && (cyc - t0 <= MC + 12)}, 16'h0001);
      repeat (300) @(posedge sys_clk);
      #1;
      check({14'h0, awake_q, int_n_q}, 16'h0000);
      @(posedge sys_clk);
      en_int_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
      #1;
      check({15'h0, int_line}, 16'h0001);
      @(posedge sys_clk);
      en_int_n <= 1'b0;
      i_host.xfer(cmd(1'b1, `ADDR_CONFIG_ONE), rx);
      i_host.xfer(cmd(1'b0, `ADDR_NOP), rx);
      check(rx, reply(14'h0001));
      // bad parity sets the sticky error flag, clear command drops it
      i_host.xfer(cmd(1'b1, `ADDR_CONFIG_ONE) ^ 16'h0001, rx);
      i_host.xfer(cmd(1'b1, `ADDR_CLR_ERROR), rx);
      check(rx, 16'h0003);
      i_host.xfer(cmd(1'b0, `ADDR_NOP), rx);
      check(rx, reply(14'h0000));
      for (i = 0; i < 5; i = i + 1) begin // successive samples
         wait_int;
         i_host.xfer(cmd(1'b1, `ADDR_ANGLE_RESULT), rx);
         check({13'h0, int_n_q, ready_q, awake_q}, 16'h0005);
         @(posedge sys_clk);
         sample <= rows[i][23:12];
         i_host.xfer(cmd(1'b0, `ADDR_NOP), rx);
         check(rx, reply({2'b00, rows[i][11:0]}));
      end
      @(posedge sys_clk);
      rst_n <= 1'b0;
      wire_mode <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      check({12'h0, int_n_q, awake_q, ready_q, miso_oe_n_q}, 16'h000D);
      @(posedge sys_clk);
      rst_n <= 1'b1;
      wait_int;
      i_host.xfer(cmd(1'b1, `ADDR_CONFIG_ONE), rx);
      i_host.xfer(cmd(1'b0, `ADDR_NOP), rx);
      check(rx, reply(14'h0001));
      check({15'h0, miso_oe_n_q}, 16'h0001);
      print_verdict;
   end
endmodule
`default_nettype wire
